/* hdl/rcfp_parser.sv */
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module rcfp_parser #(
	parameter int VAL_DEPTH = 16,
	parameter int VAL_AW    = 4
) (
	// Clock and reset.
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// AXI4-Lite slave.
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Serial API byte stream from the host.
	input  wire logic [7:0]          rx_data,
	input  wire logic                rx_valid,
	output logic                     rx_ready,
	// Request towards the network transmit path.
	output logic                     net_req_valid,
	input  wire logic                net_req_ready,
	output logic [63:0]              net_req_dest64,
	output logic [15:0]              net_req_dest16,
	output logic [15:0]              net_req_cmd,
	output logic [7:0]               net_req_options,
	output logic                     net_req_no_ack,
	output logic                     net_req_apply,
	output logic                     net_req_secure,
	output logic                     net_req_query,
	output logic                     net_req_apply_cmd,
	output logic [15:0]              net_req_val_len,
	input  wire logic [VAL_AW-1:0]   net_val_addr,
	output logic [7:0]               net_val_data,
	// Answer from the remote node.
	input  wire logic                ans_valid,
	input  wire logic [7:0]          ans_status,
	input  wire logic [31:0]         ans_value,
	// Response towards the host.
	output logic                     rsp_valid,
	output logic [7:0]               rsp_type,
	output logic [7:0]               rsp_frame_id,
	output logic [7:0]               rsp_status,
	output logic [31:0]              rsp_value
);
	import rcfp_pkg::*;

	// ------------------------------------------------------------------------
	// Declarations.
	// ------------------------------------------------------------------------
	rcfp_state_t state_ff, nxt_state;
	logic [15:0] len_ff, cnt_ff;
	logic [7:0]  sum_ff, type_ff, fid_ff, opt_ff;
	logic [63:0] dest64_ff;
	logic [15:0] dest16_ff, cmd_ff;
	logic        rx_ready_ff, req_valid_ff, rsp_valid_ff;
	logic [7:0]  rsp_fid_ff, rsp_status_ff;
	logic [31:0] rsp_value_ff;
	logic [31:0] ctrl_ff, good_cnt_ff, err_cnt_ff;
	logic        rx_take, frame_ok, frame_bad, len_bad, sum_ok;
	logic [15:0] len_full;
	logic [15:0] val_idx;
	logic        val_wr;
	logic        aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
	logic [7:0]  awaddr_ff;
	logic        wstrb0_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic        wr_fire, rd_fire, clr_pulse;

	assign rx_take  = rx_valid && rx_ready_ff;
	assign len_full = {len_ff[7:0], rx_data};
	assign sum_ok   = ((sum_ff + rx_data) == RCFP_SUM_GOOD);
	// Value bytes start after the command name.
	assign val_idx  = cnt_ff - (RCFP_IDX_CMD_LAST + 16'h0001);
	assign val_wr   = rx_take && (state_ff == RCFP_ST_BODY) && (cnt_ff > RCFP_IDX_CMD_LAST);
	// A length shorter than the fixed fields, or longer than the value store,
	// can never agree with a well formed request.
	assign len_bad  = (len_full < RCFP_MIN_LEN) ||
			(len_full > RCFP_MIN_LEN + 16'(VAL_DEPTH));

	// ------------------------------------------------------------------------
	// Parser state machine.
	// ------------------------------------------------------------------------
	// Next state; the machine falls back to delimiter hunting on any error.
	always_comb begin
		nxt_state = state_ff;
		frame_ok  = 1'b0;
		frame_bad = 1'b0;
		unique case (state_ff)
			RCFP_ST_HUNT: begin
				if (rx_take && rx_data == RCFP_START_DELIM) begin
					nxt_state = RCFP_ST_LEN_HI;
				end
			end
			RCFP_ST_LEN_HI: begin
				if (rx_take) begin
					nxt_state = RCFP_ST_LEN_LO;
				end
			end
			RCFP_ST_LEN_LO: begin
				if (rx_take) begin
					if (len_bad) begin
						frame_bad = 1'b1;
						nxt_state = RCFP_ST_HUNT;
					end else begin
						nxt_state = RCFP_ST_BODY;
					end
				end
			end
			RCFP_ST_BODY: begin
				if (rx_take && cnt_ff == len_ff - 16'h0001) begin
					nxt_state = RCFP_ST_SUM;
				end
			end
			RCFP_ST_SUM: begin
				if (rx_take) begin
					if (!sum_ok) begin
						frame_bad = 1'b1;
						nxt_state = RCFP_ST_HUNT;
					end else if (type_ff == RCFP_TYPE_REQ) begin
						frame_ok  = 1'b1;
						nxt_state = RCFP_ST_REQ;
					end else begin
						nxt_state = RCFP_ST_HUNT;
					end
				end
			end
			RCFP_ST_REQ: begin
				if (net_req_ready) begin
					nxt_state = RCFP_ST_WAIT;
				end
			end
			RCFP_ST_WAIT: begin
				if (ans_valid) begin
					nxt_state = RCFP_ST_HUNT;
				end
			end
		endcase
	end

	// State register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= RCFP_ST_HUNT;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// The link is held off while a request is out, so the captured fields
	// stay stable; a disabled parser stalls the host rather than drop bytes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_ready_ff <= 1'b0;
		end else begin
			rx_ready_ff <= ctrl_ff[RCFP_CTRL_EN_BIT] &&
					(nxt_state != RCFP_ST_REQ) && (nxt_state != RCFP_ST_WAIT);
		end
	end

	// ------------------------------------------------------------------------
	// Length, byte count and running sum.
	// ------------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			len_ff <= 16'h0000;
			cnt_ff <= 16'h0000;
			sum_ff <= 8'h00;
		end else if (rx_take) begin
			unique case (state_ff)
				RCFP_ST_LEN_HI: len_ff <= {8'h00, rx_data};
				RCFP_ST_LEN_LO: begin
					len_ff <= len_full;
					cnt_ff <= 16'h0000;
					sum_ff <= 8'h00;
				end
				RCFP_ST_BODY: begin
					cnt_ff <= cnt_ff + 16'h0001;
					sum_ff <= sum_ff + rx_data;
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Field capture.
	// ------------------------------------------------------------------------
	// Multi-byte fields shift in from the low end, most significant first.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			type_ff   <= 8'h00;
			fid_ff    <= 8'h00;
			dest64_ff <= 64'h0000_0000_0000_0000;
			dest16_ff <= 16'h0000;
			opt_ff    <= 8'h00;
			cmd_ff    <= 16'h0000;
		end else if (rx_take && state_ff == RCFP_ST_BODY) begin
			if (cnt_ff == RCFP_IDX_TYPE) begin
				type_ff <= rx_data;
			end else if (cnt_ff == RCFP_IDX_FID) begin
				fid_ff <= rx_data;
			end else if (cnt_ff <= RCFP_IDX_D64_LAST) begin
				dest64_ff <= {dest64_ff[55:0], rx_data};
			end else if (cnt_ff <= RCFP_IDX_D16_LAST) begin
				dest16_ff <= {dest16_ff[7:0], rx_data};
			end else if (cnt_ff == RCFP_IDX_OPT) begin
				opt_ff <= rx_data & RCFP_OPT_MASK;
			end else if (cnt_ff <= RCFP_IDX_CMD_LAST) begin
				cmd_ff <= {cmd_ff[7:0], rx_data};
			end
		end
	end

	// Value bytes go to the store at their offset inside the value field.
	rcfp_value_mem #(
		.DEPTH      (VAL_DEPTH),
		.AW         (VAL_AW)
	) u_value_mem (
		.aclk       (aclk),
		.wr_en      (val_wr),
		.wr_addr    (val_idx[VAL_AW-1:0]),
		.wr_data    (rx_data),
		.rd_addr    (net_val_addr),
		.rd_data_ff (net_val_data)
	);

	// ------------------------------------------------------------------------
	// Network request and host response.
	// ------------------------------------------------------------------------
	// The request is raised only for a frame that passed every check.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_valid_ff <= 1'b0;
		end else if (frame_ok) begin
			req_valid_ff <= 1'b1;
		end else if (net_req_ready) begin
			req_valid_ff <= 1'b0;
		end
	end

	// A zero identifier still sends the request but returns nothing.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsp_valid_ff  <= 1'b0;
			rsp_fid_ff    <= 8'h00;
			rsp_status_ff <= 8'h00;
			rsp_value_ff  <= 32'h0000_0000;
		end else begin
			rsp_valid_ff <= (state_ff == RCFP_ST_WAIT) && ans_valid &&
					(fid_ff != 8'h00);
			if (state_ff == RCFP_ST_WAIT && ans_valid) begin
				rsp_fid_ff    <= fid_ff;
				rsp_status_ff <= ans_status;
				rsp_value_ff  <= ans_value;
			end
		end
	end

	assign net_req_valid     = req_valid_ff;
	assign net_req_dest64    = dest64_ff;
	assign net_req_dest16    = dest16_ff;
	assign net_req_cmd       = cmd_ff;
	assign net_req_options   = opt_ff;
	assign net_req_no_ack    = opt_ff[RCFP_OPT_NO_ACK];
	assign net_req_apply     = opt_ff[RCFP_OPT_APPLY];
	assign net_req_secure    = opt_ff[RCFP_OPT_SECURE];
	assign net_req_query     = (len_ff == RCFP_MIN_LEN);
	assign net_req_apply_cmd = (cmd_ff == RCFP_APPLY_CMD);
	assign net_req_val_len   = len_ff - RCFP_MIN_LEN;
	assign rx_ready          = rx_ready_ff;
	assign rsp_valid         = rsp_valid_ff;
	assign rsp_type          = RCFP_TYPE_RSP;
	assign rsp_frame_id      = rsp_fid_ff;
	assign rsp_status        = rsp_status_ff;
	assign rsp_value         = rsp_value_ff;

	// ------------------------------------------------------------------------
	// Frame counters.
	// ------------------------------------------------------------------------
	// A frame event in the clearing cycle still counts, so none is lost.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			good_cnt_ff <= 32'h0000_0000;
			err_cnt_ff  <= 32'h0000_0000;
		end else begin
			if (clr_pulse) begin
				good_cnt_ff <= {31'h0, frame_ok};
				err_cnt_ff  <= {31'h0, frame_bad};
			end else begin
				good_cnt_ff <= good_cnt_ff + {31'h0, frame_ok};
				err_cnt_ff  <= err_cnt_ff + {31'h0, frame_bad};
			end
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite write channel.
	// ------------------------------------------------------------------------
	assign wr_fire   = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign clr_pulse = wr_fire && (awaddr_ff == RCFP_REG_CTRL) && wdata_ff[RCFP_CTRL_CLR_BIT];

	// Address and data are latched independently, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h0000_0000;
			wstrb0_ff  <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_hold_ff) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_hold_ff <= 1'b0;
			end
			if (s_axi_wvalid && !w_hold_ff) begin
				w_hold_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb0_ff <= s_axi_wstrb[0]; // The strobe is payload and may move once taken.
			end else if (wr_fire) begin
				w_hold_ff <= 1'b0;
			end
		end
	end

	// Only the enable bit is stored; the clear bit acts once and is not kept.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= RCFP_CTRL_RESET;
		end else if (wr_fire && awaddr_ff == RCFP_REG_CTRL && wstrb0_ff) begin
			ctrl_ff <= {31'h0, wdata_ff[RCFP_CTRL_EN_BIT]};
		end
	end

	// Write response; read-only and unmapped offsets answer SLVERR.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RCFP_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (awaddr_ff == RCFP_REG_CTRL) ? RCFP_RESP_OKAY : RCFP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_awready = !aw_hold_ff;
	assign s_axi_wready  = !w_hold_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	// ------------------------------------------------------------------------
	// AXI4-Lite read channel.
	// ------------------------------------------------------------------------
	assign rd_fire = s_axi_arvalid && !rvalid_ff;

	// One cycle from address to data; the status word shows the parser state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= RCFP_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= RCFP_RESP_OKAY;
			unique case (s_axi_araddr)
				RCFP_REG_CTRL:     rdata_ff <= ctrl_ff;
				RCFP_REG_STATUS:   rdata_ff <= {28'h000_0000, req_valid_ff, 3'(state_ff)};
				RCFP_REG_GOOD_CNT: rdata_ff <= good_cnt_ff;
				RCFP_REG_ERR_CNT:  rdata_ff <= err_cnt_ff;
				RCFP_REG_LAST:     rdata_ff <= {8'h00, cmd_ff, fid_ff};
				default: begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= RCFP_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

endmodule
`default_nettype wire

/* hdl/rcfp_pkg.sv */
// ----------------------------------------------------------------------------
// Shared constants of the remote parameter request frame parser.
// ----------------------------------------------------------------------------
package rcfp_pkg;

	// ------------------------------------------------------------------------
	// Frame layout.
	// ------------------------------------------------------------------------
	localparam logic [7:0]  RCFP_START_DELIM   = 8'h7E; // Start of every frame.
	localparam logic [7:0]  RCFP_TYPE_REQ      = 8'h17; // Remote parameter request.
	localparam logic [7:0]  RCFP_TYPE_RSP      = 8'h97; // Matching response type.
	localparam logic [7:0]  RCFP_SUM_GOOD      = 8'hFF; // Body sum plus checksum.
	localparam logic [15:0] RCFP_MIN_LEN       = 16'h000F; // Type through command name.
	localparam logic [15:0] RCFP_IDX_TYPE      = 16'h0000; // Body index of frame type.
	localparam logic [15:0] RCFP_IDX_FID       = 16'h0001; // Body index of frame identifier.
	localparam logic [15:0] RCFP_IDX_D64_LAST  = 16'h0009; // Last byte of long identifier.
	localparam logic [15:0] RCFP_IDX_D16_LAST  = 16'h000B; // Last byte of network address.
	localparam logic [15:0] RCFP_IDX_OPT       = 16'h000C; // Body index of option byte.
	localparam logic [15:0] RCFP_IDX_CMD_LAST  = 16'h000E; // Last byte of command name.
	localparam logic [15:0] RCFP_APPLY_CMD     = 16'h4143; // apply_pending_changes_cmd name.

	// ------------------------------------------------------------------------
	// Option bit positions.
	// ------------------------------------------------------------------------
	localparam int          RCFP_OPT_NO_ACK    = 0;
	localparam int          RCFP_OPT_APPLY     = 1;
	localparam int          RCFP_OPT_SECURE    = 4;
	localparam logic [7:0]  RCFP_OPT_MASK      = 8'h13; // Defined option bits only.

	// ------------------------------------------------------------------------
	// Register map, byte addresses on the AXI4-Lite bus.
	// ------------------------------------------------------------------------
	localparam logic [7:0]  RCFP_REG_CTRL      = 8'h00;
	localparam logic [7:0]  RCFP_REG_STATUS    = 8'h04;
	localparam logic [7:0]  RCFP_REG_GOOD_CNT  = 8'h08;
	localparam logic [7:0]  RCFP_REG_ERR_CNT   = 8'h0C;
	localparam logic [7:0]  RCFP_REG_LAST      = 8'h10;
	localparam int          RCFP_CTRL_EN_BIT   = 0;
	localparam int          RCFP_CTRL_CLR_BIT  = 1;
	localparam logic [31:0] RCFP_CTRL_RESET    = 32'h0000_0001; // Parser on.
	localparam logic [1:0]  RCFP_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RCFP_RESP_SLVERR   = 2'h2;

	// ------------------------------------------------------------------------
	// Parser states.
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		RCFP_ST_HUNT,
		RCFP_ST_LEN_HI,
		RCFP_ST_LEN_LO,
		RCFP_ST_BODY,
		RCFP_ST_SUM,
		RCFP_ST_REQ,
		RCFP_ST_WAIT
	} rcfp_state_t;

endpackage

/* hdl/rcfp_value_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Value byte store: one write port, registered read port.
// ----------------------------------------------------------------------------
module rcfp_value_mem #(
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	// Clock.
	input  wire logic          aclk,
	// Write side.
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	// Read side.
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data_ff
);

	logic [7:0] mem [DEPTH];

	// Storage carries no reset, so it maps onto plain RAM cells.
	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Read data leave through a register, one cycle after the address.
	always_ff @(posedge aclk) begin
		rd_data_ff <= mem[rd_addr];
	end

endmodule
`default_nettype wire

/* verif/rcfp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Host side of the serial byte link.
// ----------------------------------------------------------------------------
module rcfp_host_model (
	// Clock.
	input  wire logic       aclk,
	// Byte link.
	output var  logic [7:0] rx_data,
	output var  logic       rx_valid,
	input  wire logic       rx_ready
);
	// Idle line shows the inverse of the last byte, so a stale byte is never reused.
	initial begin
		rx_data  = 8'h00;
		rx_valid = 1'b0;
	end

	// Each byte stands until the edge that takes it.
	task automatic send_raw(input logic [7:0] q[$]);
		@(posedge aclk);
		foreach (q[i]) begin
			rx_data  <= q[i];
			rx_valid <= 1'b1;
			do @(posedge aclk); while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		rx_data  <= ~q[q.size()-1];
	endtask

	// Wraps a body with delimiter, length and checksum; bad flips one checksum bit.
	task automatic send_frame(input logic [7:0] body[$], input bit bad);
		logic [7:0] f[$];
		logic [7:0] s;
		s = 8'h00;
		foreach (body[i]) s += body[i];
		f = {8'h7E, 8'(body.size() >> 8), 8'(body.size()), body};
		f.push_back((8'hFF - s) ^ {7'h00, bad});
		send_raw(f);
	endtask
endmodule
`default_nettype wire

/* verif/rcfp_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module rcfp_monitor
	import rcfp_pkg::*;
(
	// Clock and reset.
	input wire logic        aclk,
	input wire logic        aresetn,
	// Link and request side.
	input wire logic        rx_ready,
	input wire logic        net_req_valid,
	input wire logic        net_req_ready,
	input wire logic [15:0] net_req_cmd,
	input wire logic [7:0]  net_req_options,
	input wire logic        net_req_no_ack,
	input wire logic        net_req_apply,
	input wire logic        net_req_secure,
	input wire logic        net_req_query,
	input wire logic        net_req_apply_cmd,
	input wire logic [15:0] net_req_val_len,
	input wire logic [63:0] net_req_dest64,
	// Answer and response.
	input wire logic        ans_valid,
	input wire logic        rsp_valid,
	input wire logic [7:0]  rsp_type
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// A request waiting for the transmit path.
	sequence s_req_held;
		net_req_valid && !net_req_ready;
	endsequence

	// Fields may not move under a pending request, or the wrong node is addressed.
	a_req_stable: assert property (s_req_held |=> net_req_valid && $stable(net_req_cmd)
		&& $stable(net_req_dest64) && $stable(net_req_val_len))
		else $error("request fields moved while pending");
	a_opt_mask: assert property (net_req_valid |-> (net_req_options & ~RCFP_OPT_MASK) == 8'h00)
		else $error("reserved option bits forwarded");
	a_opt_bits: assert property (net_req_valid |-> {net_req_no_ack, net_req_apply, net_req_secure}
		== {net_req_options[0], net_req_options[1], net_req_options[4]})
		else $error("option flags disagree with option byte");
	a_query_len: assert property (net_req_valid |-> net_req_query == (net_req_val_len == 16'h0000))
		else $error("query flag wrong");
	a_apply_name: assert property (net_req_valid |-> net_req_apply_cmd == (net_req_cmd == RCFP_APPLY_CMD))
		else $error("apply command flag wrong");
	a_len_range: assert property (net_req_valid |-> net_req_val_len <= 16'h0010)
		else $error("value length beyond store");
	a_rx_stall: assert property (net_req_valid |-> !rx_ready)
		else $error("link not stalled during request");
	a_rsp_type: assert property (rsp_valid |-> rsp_type == RCFP_TYPE_RSP)
		else $error("response type wrong");
	a_rsp_cause: assert property (rsp_valid |-> $past(ans_valid) || $past(ans_valid, 2))
		else $error("response without answer");
endmodule

bind rcfp_parser rcfp_monitor u_mon (.aclk, .aresetn, .rx_ready, .net_req_valid, .net_req_ready,
	.net_req_cmd, .net_req_options, .net_req_no_ack, .net_req_apply, .net_req_secure,
	.net_req_query, .net_req_apply_cmd, .net_req_val_len, .net_req_dest64, .ans_valid,
	.rsp_valid, .rsp_type);
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rcfp_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, rx_valid, rx_ready, net_req_valid, net_req_ready, ans_valid;
	logic        net_req_no_ack, net_req_apply, net_req_secure, net_req_query, net_req_apply_cmd;
	logic        rsp_valid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_data, ans_status, rsp_type, rsp_frame_id;
	logic [7:0]  rsp_status, net_req_options, net_val_data;
	logic [31:0] s_axi_wdata, s_axi_rdata, ans_value, rsp_value;
	logic [3:0]  s_axi_wstrb, net_val_addr;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [63:0] net_req_dest64;
	logic [15:0] net_req_dest16, net_req_cmd, net_req_val_len;
	logic [7:0]  b[$];
	int          num_errors, samples_checked, rsp_cnt;

	rcfp_parser DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .rx_data, .rx_valid, .rx_ready, .net_req_valid, .net_req_ready,
		.net_req_dest64, .net_req_dest16, .net_req_cmd, .net_req_options, .net_req_no_ack,
		.net_req_apply, .net_req_secure, .net_req_query, .net_req_apply_cmd, .net_req_val_len,
		.net_val_addr, .net_val_data, .ans_valid, .ans_status, .ans_value, .rsp_valid, .rsp_type,
		.rsp_frame_id, .rsp_status, .rsp_value);
	rcfp_host_model HOST (.aclk, .rx_data, .rx_valid, .rx_ready);

	// Clock; responses are counted per cycle so a stretched pulse shows up.
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) if (rsp_valid === 1'b1) rsp_cnt++;

	task automatic complete_run();
		if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk({s_axi_rresp, s_axi_rdata}, {r, e});
	endtask

	// A dropped or foreign frame must never reach the transmit path.
	task automatic expect_quiet();
		int n;
		n = 0;
		repeat (30) @(posedge aclk) if (net_req_valid !== 1'b0) n++;
		chk(n, 0);
	endtask

	// One request frame, checked at the transmit side and answered.
	task automatic run_frame(input int i);
		logic [7:0]  id, op, st;
		logic [15:0] cmd, d16;
		logic [63:0] d64;
		logic [31:0] v;
		int          vl, n, rc;
		id  = (i == 0) ? 8'h00 : 8'($urandom_range(1, 255));
		op  = 8'($urandom) & RCFP_OPT_MASK;
		cmd = (i == 3) ? RCFP_APPLY_CMD : 16'({$urandom_range(65, 90), 8'($urandom_range(65, 90))});
		d64 = i[0] ? '1 : {$urandom, $urandom};
		d16 = i[0] ? 16'($urandom_range(0, 65519)) : 16'hFFFE;
		vl  = (i == 1) ? 16 : $urandom_range(0, 4);
		b   = {RCFP_TYPE_REQ, id};
		for (n = 7; n >= 0; n--) b.push_back(d64[8*n +: 8]);
		b = {b, d16[15:8], d16[7:0], op, cmd[15:8], cmd[7:0]};
		repeat (vl) b.push_back(8'($urandom));
		HOST.send_frame(b, 1'b0);
		n = 0;
		do @(posedge aclk); while (net_req_valid !== 1'b1 && ++n < 20);
		chk(net_req_valid, 1'b1);
		chk(net_req_dest64, d64);
		chk({net_req_dest16, net_req_cmd, net_req_options}, {d16, cmd, op});
		chk({net_req_no_ack, net_req_apply, net_req_secure}, {op[0], op[1], op[4]});
		chk({net_req_query, net_req_apply_cmd}, {vl == 0, cmd == RCFP_APPLY_CMD});
		chk(net_req_val_len, vl);
		if (i == 2) axi_rd(RCFP_REG_STATUS, 32'h0000_000D, RCFP_RESP_OKAY);
		for (n = 0; n < vl; n++) begin
			@(posedge aclk) net_val_addr <= 4'(n);
			@(posedge aclk) #1 chk(net_val_data, b[15+n]);
		end
		repeat ($urandom_range(1, 5)) @(posedge aclk);
		net_req_ready <= 1'b1;
		@(posedge aclk) net_req_ready <= 1'b0;
		if (i == 2) axi_rd(RCFP_REG_STATUS, 32'h0000_0006, RCFP_RESP_OKAY);
		v  = $urandom;
		st = 8'($urandom);
		rc = rsp_cnt;
		@(posedge aclk) {ans_valid, ans_status, ans_value} <= {1'b1, st, v};
		@(posedge aclk) ans_valid <= 1'b0;
		repeat (4) @(posedge aclk);
		chk(rsp_cnt - rc, id != 8'h00);
		if (id != 8'h00) chk({rsp_frame_id, rsp_status, rsp_value}, {id, st, v});
		if (i == 4) axi_rd(RCFP_REG_LAST, {8'h00, cmd, id}, RCFP_RESP_OKAY);
	endtask

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, net_val_addr} = '0;
		{net_req_ready, ans_valid, ans_status, ans_value} = '0;
		{num_errors, samples_checked, rsp_cnt} = '0;
		s_axi_wstrb = 4'hF;
		void'($urandom(21169));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		axi_rd(RCFP_REG_CTRL, RCFP_CTRL_RESET, RCFP_RESP_OKAY);
		axi_rd(RCFP_REG_STATUS, 32'h0, RCFP_RESP_OKAY);
		axi_rd(8'h14, 32'h0, RCFP_RESP_SLVERR);
		axi_wr(8'h14, 32'hFFFF_FFFF, RCFP_RESP_SLVERR);
		b = {8'h08, 8'h01};
		repeat (13) b.push_back(8'h4E);
		HOST.send_frame(b, 1'b0);
		expect_quiet();
		axi_wr(RCFP_REG_CTRL, 32'h0000_0003, RCFP_RESP_OKAY);
		axi_rd(RCFP_REG_CTRL, 32'h0000_0001, RCFP_RESP_OKAY);
		axi_rd(RCFP_REG_GOOD_CNT, 32'h0, RCFP_RESP_OKAY);
		for (int i = 0; i < 12; i++) run_frame(i);
		b = {RCFP_TYPE_REQ, 8'h11};
		repeat (13) b.push_back(8'h00);
		HOST.send_frame(b, 1'b1);
		expect_quiet();
		HOST.send_raw('{8'h55, 8'h7E, 8'h00, 8'h0E});
		expect_quiet();
		HOST.send_raw('{8'h7E, 8'h00, 8'h20});
		expect_quiet();
		run_frame(12);
		axi_rd(RCFP_REG_GOOD_CNT, 32'd13, RCFP_RESP_OKAY);
		axi_rd(RCFP_REG_ERR_CNT, 32'd3, RCFP_RESP_OKAY);
		axi_wr(RCFP_REG_CTRL, 32'h0, RCFP_RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(rx_ready, 1'b0);
		ans_valid <= 1'b1;
		@(posedge aclk) ans_valid <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(rsp_cnt, 12);
		axi_wr(RCFP_REG_CTRL, 32'h1, RCFP_RESP_OKAY);
		complete_run();
	end

	// Watchdog well beyond the thousand or so cycles the sequence needs.
	initial begin
		repeat (30000) @(posedge aclk);
		num_errors++;
		complete_run();
	end
endmodule
`default_nettype wire
